// >>> pfrc_top.sv
// Power-fail resume, button and supply-timeout control with AXI4-Lite registers.
// Assumes inputs synchronous to aclk; standby power-up shown by standby_por_pulse.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Overview of operation
// RQ1: Control register resets to 87h
// RQ2: Wake flag set at standby power-up, W1C
// RQ3: Stored supply-on state is read-only
// RQ4: Mode 00 resumes on external S3 only
// RQ5: Mode 01 adds RTC alarm resume
// RQ6: Mode 10 restores, 11 restores or alarm
// RQ7: Button pulse only when output mode 0
// RQ8: ACPI mode: off by sleep or override
// RQ9: Legacy mode: button press turns supply off
// RQ10: Legacy bit cleared by main reset too
// RQ11: Timeout field selects 0.5 to 20 s
// RQ12: Supply dropped if main stays off
// RQ13: Buttons ignored one second after timeout
// RQ14: Timeout sets W1C flag in misc register
// RQ15: Resume decided once at standby return
module pfrc_top #(
	parameter int unsigned MS_CYC = pfrc_pkg::CYC_PER_MS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Power domain events
	input wire logic standby_por_pulse,
	input wire logic main_por_pulse,
	input wire logic last_on_at_outage,
	input wire logic rtc_alarm_in_outage,
	// System inputs
	input wire pfrc_pkg::pfrc_sys_t sys_in,
	input wire logic button_press_in,
	// Power outputs
	output logic supply_on_out_n,
	output logic button_pulse_out,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [1:0] {
		PFRC_OFF,
		PFRC_WAIT_GOOD,
		PFRC_ON,
		PFRC_GUARD
	} pfrc_state_t;

	logic woke_from_total_outage_q;
	logic stored_supply_on_state_q;
	logic [1:0] outage_resume_select_q;
	logic legacy_button_select_q;
	logic [2:0] supply_fail_timeout_sel_q;
	logic external_sleep_select_q;
	logic button_output_mode_q;
	logic supply_fail_timeout_flag_q;
	logic [2:0] irq_sts_q;
	logic [2:0] irq_mask_q;
	logic resume_pending_q;
	logic alarm_seen_q;
	pfrc_state_t state_q;
	// Prescaler wide enough for one millisecond at full clock rate
	logic [17:0] ms_sub_q;
	logic [14:0] ms_cnt_q;
	// Stretches the button pulse to its full length
	logic [4:0] pulse_cnt_q;
	logic btn_prev_q;

	logic aw_held_q, w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire, rd_fire, wr_hit_pwon, wr_hit_misc, wr_hit_sts, wr_hit_mask;
	logic [7:0] pwon_rd;
	logic resume_on, off_req, btn_edge, ms_tick, tout_expire, guard_done, want_pulse;
	logic [2:0] irq_events;
	logic [14:0] tout_ms;

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_fire = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	assign wa = aw_held_q ? awaddr_q : s_axi_awaddr;
	assign wd = w_held_q ? wdata_q : s_axi_wdata;
	assign ws = w_held_q ? wstrb_q : s_axi_wstrb;
	assign wr_hit_pwon = wr_fire && ws[0] && (wa == pfrc_pkg::PWON_ADDR);
	assign wr_hit_misc = wr_fire && ws[0] && (wa == pfrc_pkg::MISC_ADDR);
	assign wr_hit_sts = wr_fire && ws[0] && (wa == pfrc_pkg::IRQ_STS_ADDR);
	assign wr_hit_mask = wr_fire && ws[0] && (wa == pfrc_pkg::IRQ_MASK_ADDR);

	always_ff @(posedge aclk) begin
		if (!aresetn || wr_fire) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pfrc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (wa == pfrc_pkg::PWON_ADDR || wa == pfrc_pkg::MISC_ADDR || wa == pfrc_pkg::IRQ_STS_ADDR
				|| wa == pfrc_pkg::IRQ_MASK_ADDR) begin
				s_axi_bresp <= pfrc_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= pfrc_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign pwon_rd = {woke_from_total_outage_q, stored_supply_on_state_q, outage_resume_select_q,
		legacy_button_select_q, supply_fail_timeout_sel_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= pfrc_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pfrc_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr == pfrc_pkg::PWON_ADDR) begin
				s_axi_rdata[7:0] <= pwon_rd;
			end else if (s_axi_araddr == pfrc_pkg::MISC_ADDR) begin
				s_axi_rdata[pfrc_pkg::EXT_SEL_BIT] <= external_sleep_select_q;
				s_axi_rdata[pfrc_pkg::BTN_MODE_BIT] <= button_output_mode_q;
				s_axi_rdata[pfrc_pkg::TOUT_FLAG_BIT] <= supply_fail_timeout_flag_q;
			end else if (s_axi_araddr == pfrc_pkg::IRQ_STS_ADDR) begin
				s_axi_rdata[2:0] <= irq_sts_q;
			end else if (s_axi_araddr == pfrc_pkg::IRQ_MASK_ADDR) begin
				s_axi_rdata[2:0] <= irq_mask_q;
			end else begin
				s_axi_rresp <= pfrc_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Standby-well fields of power_on_control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			woke_from_total_outage_q <= pfrc_pkg::PWON_RESET[pfrc_pkg::WAKE_BIT]; // [RQ1]
			outage_resume_select_q <= pfrc_pkg::PWON_RESET[pfrc_pkg::MODE_LSB +: 2];
			supply_fail_timeout_sel_q <= pfrc_pkg::TOUT_RESET; // [RQ11]
		end else begin
			if (standby_por_pulse) begin
				woke_from_total_outage_q <= 1'b1; // [RQ2]
			end else if (wr_hit_pwon && wd[pfrc_pkg::WAKE_BIT]) begin
				woke_from_total_outage_q <= 1'b0; // [RQ2]
			end
			if (wr_hit_pwon) begin
				outage_resume_select_q <= wd[pfrc_pkg::MODE_LSB +: 2];
				supply_fail_timeout_sel_q <= wd[pfrc_pkg::TOUT_LSB +: 3];
			end
		end
	end

	// Outage snapshot, read-only to software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stored_supply_on_state_q <= pfrc_pkg::PWON_RESET[pfrc_pkg::LAST_BIT]; // [RQ3]
			alarm_seen_q <= 1'b0;
			resume_pending_q <= 1'b0;
		end else if (standby_por_pulse) begin
			stored_supply_on_state_q <= last_on_at_outage; // [RQ3]
			alarm_seen_q <= rtc_alarm_in_outage;
			resume_pending_q <= 1'b1; // [RQ15]
		end else begin
			resume_pending_q <= 1'b0;
		end
	end

	// Main-well legacy button bit
	always_ff @(posedge aclk) begin
		if (!aresetn || main_por_pulse) begin
			legacy_button_select_q <= 1'b0; // [RQ10]
		end else if (wr_hit_pwon) begin
			legacy_button_select_q <= wd[pfrc_pkg::LEGACY_BIT];
		end
	end

	// Misc control and timeout flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			external_sleep_select_q <= 1'b0;
			button_output_mode_q <= 1'b0;
			supply_fail_timeout_flag_q <= 1'b0;
		end else begin
			if (wr_hit_misc) begin
				external_sleep_select_q <= wd[pfrc_pkg::EXT_SEL_BIT];
				button_output_mode_q <= wd[pfrc_pkg::BTN_MODE_BIT];
			end
			if (tout_expire) begin
				supply_fail_timeout_flag_q <= 1'b1; // [RQ14]
			end else if (wr_hit_misc && wd[pfrc_pkg::TOUT_FLAG_BIT]) begin
				supply_fail_timeout_flag_q <= 1'b0; // [RQ14]
			end
		end
	end

	// Resume decision table
	// Sleep pin read live, in the cycle after the power-up pulse
	always_comb begin
		case (pfrc_pkg::pfrc_mode_t'(outage_resume_select_q))
			pfrc_pkg::PFRC_MODE_S3ONLY: resume_on = external_sleep_select_q && sys_in.sleep_s3_in; // [RQ4]
			pfrc_pkg::PFRC_MODE_ALARM: resume_on = alarm_seen_q
				|| (external_sleep_select_q && sys_in.sleep_s3_in); // [RQ5]
			pfrc_pkg::PFRC_MODE_RESTORE: resume_on = stored_supply_on_state_q; // [RQ6]
			default: resume_on = stored_supply_on_state_q || alarm_seen_q; // [RQ6]
		endcase
	end

	assign btn_edge = button_press_in && !btn_prev_q;
	assign off_req = legacy_button_select_q ? btn_edge // [RQ9]
		: ((sys_in.sleep_type_wr && sys_in.sleep_type_field != 3'h0) || sys_in.sleep_s3_in
		|| sys_in.sleep_s5_in || sys_in.override_in); // [RQ8]
	assign tout_ms = 15'(pfrc_pkg::TIMEOUT_MS[supply_fail_timeout_sel_q]); // [RQ11]
	assign ms_tick = (ms_sub_q == 18'(MS_CYC - 1));
	assign tout_expire = (state_q == PFRC_WAIT_GOOD) && ms_tick && (ms_cnt_q == tout_ms - 15'h0001)
		&& !sys_in.main_supply_good; // [RQ12]
	assign guard_done = (state_q == PFRC_GUARD) && ms_tick
		&& (ms_cnt_q == 15'(pfrc_pkg::GUARD_MS - 1)); // [RQ13]
	assign want_pulse = resume_pending_q && resume_on && !button_output_mode_q; // [RQ7]

	// Supply sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= PFRC_OFF;
			ms_sub_q <= 18'h0_0000;
			ms_cnt_q <= 15'h0000;
			btn_prev_q <= 1'b0;
		end else begin
			btn_prev_q <= button_press_in;
			ms_sub_q <= (ms_tick || state_q == PFRC_OFF || state_q == PFRC_ON) ? 18'h0_0000
				: ms_sub_q + 18'h0_0001;
			if (ms_tick) begin
				ms_cnt_q <= ms_cnt_q + 15'h0001;
			end
			case (state_q)
				PFRC_OFF: begin
					ms_cnt_q <= 15'h0000;
					if (resume_pending_q ? resume_on : btn_edge) begin
						state_q <= PFRC_WAIT_GOOD;
					end
				end
				PFRC_WAIT_GOOD: begin
					if (sys_in.main_supply_good) begin
						state_q <= PFRC_ON;
					end else if (tout_expire) begin
						state_q <= PFRC_GUARD; // [RQ12]
						ms_cnt_q <= 15'h0000;
					end
				end
				PFRC_ON: begin
					ms_cnt_q <= 15'h0000;
					if (off_req) begin
						state_q <= PFRC_OFF;
					end
				end
				default: begin
					if (guard_done) begin
						state_q <= PFRC_OFF; // [RQ13]
					end
				end
			endcase
		end
	end

	// Supply enable follows state; button pulse lasts the full pulse count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_on_out_n <= 1'b1;
			pulse_cnt_q <= 5'h00;
			button_pulse_out <= 1'b0;
		end else begin
			supply_on_out_n <= !(state_q == PFRC_WAIT_GOOD || state_q == PFRC_ON);
			if (want_pulse) begin
				pulse_cnt_q <= 5'(pfrc_pkg::BUTTON_PULSE_CYC); // [RQ7]
			end else if (pulse_cnt_q != 5'h00) begin
				pulse_cnt_q <= pulse_cnt_q - 5'h01;
			end
			button_pulse_out <= want_pulse || (pulse_cnt_q > 5'h01);
		end
	end

	// Interrupts: sticky status, W1C, set wins
	// Bits: dropped while on, resumed, timed out
	assign irq_events = {(state_q == PFRC_ON) && off_req, resume_pending_q && resume_on, tout_expire};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sts_q <= 3'h0;
			irq_mask_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_sts_q <= irq_events | (irq_sts_q & ~(wr_hit_sts ? wd[2:0] : 3'h0));
			if (wr_hit_mask) begin
				irq_mask_q <= wd[2:0];
			end
			irq <= |(irq_sts_q & irq_mask_q);
		end
	end
endmodule : pfrc_top

// >>> pfrc_pkg.sv
// Constants and carriers for the power-fail resume control block.
// Assumes a 250 MHz aclk and AXI4-Lite register access.
package pfrc_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned TIMEOUT_MS [8] = '{500, 1000, 2000, 3000, 6000, 10000, 15000, 20000};
	localparam int unsigned GUARD_MS = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned BUTTON_PULSE_NS = 100;
	localparam int unsigned BUTTON_PULSE_CYC = (BUTTON_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Byte addresses (index times four)
	localparam int unsigned PWON_IDX = 9;
	localparam logic [7:0] PWON_ADDR = 8'(PWON_IDX * 4);
	localparam logic [7:0] IRQ_STS_ADDR = 8'h40;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h44;
	localparam logic [7:0] MISC_ADDR = 8'h48;
	// Field positions of power_on_control
	localparam int unsigned WAKE_BIT = 7;
	localparam int unsigned LAST_BIT = 6;
	localparam int unsigned MODE_LSB = 4;
	localparam int unsigned LEGACY_BIT = 3;
	localparam int unsigned TOUT_LSB = 0;
	localparam logic [7:0] PWON_RESET = 8'h87;
	localparam logic [2:0] TOUT_RESET = 3'h7;
	// Misc control bits
	localparam int unsigned EXT_SEL_BIT = 0;
	localparam int unsigned BTN_MODE_BIT = 1;
	localparam int unsigned TOUT_FLAG_BIT = 4;
	// Interrupt status bits
	localparam int unsigned IRQ_TOUT = 0;
	localparam int unsigned IRQ_RESUMED = 1;
	localparam int unsigned IRQ_BTN_OFF = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		PFRC_MODE_S3ONLY,
		PFRC_MODE_ALARM,
		PFRC_MODE_RESTORE,
		PFRC_MODE_ONORALARM
	} pfrc_mode_t;
	typedef struct packed {
		logic sleep_s3_in;
		logic sleep_s5_in;
		logic [2:0] sleep_type_field;
		logic sleep_type_wr;
		logic override_in;
		logic main_supply_good;
	} pfrc_sys_t;
endpackage : pfrc_pkg

// >>> pfrc_top_props.sv
// Port checks for the power-fail resume block: AXI handshakes and supply timing.
// Bound to pfrc_top from the testbench; one clock domain, synchronous reset.
`timescale 1ns/1ns
module pfrc_top_props #(
	parameter int unsigned MS_CYC = pfrc_pkg::CYC_PER_MS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// System side
	input wire pfrc_pkg::pfrc_sys_t sys_in,
	input wire logic supply_on_out_n,
	// AXI4-Lite
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam longint LIM = longint'(pfrc_pkg::TIMEOUT_MS[7]) * MS_CYC + 4;
	localparam int GRD = int'(pfrc_pkg::GUARD_MS * MS_CYC) - 2;
	longint off_q;
	int guard_q;
	// Cycles the supply is enabled without power good
	always_ff @(posedge aclk) begin
		if (!aresetn || supply_on_out_n || sys_in.main_supply_good) off_q <= 0;
		else off_q <= off_q + 1;
	end
	// Button guard window after a timeout drop
	always_ff @(posedge aclk) begin
		if (!aresetn) guard_q <= 0;
		else if ($rose(supply_on_out_n) && !sys_in.main_supply_good) guard_q <= GRD;
		else if (guard_q != 0) guard_q <= guard_q - 1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_wr_answer: assert property (s_wr_take |=> s_axi_bvalid) else $error("write response late");
	chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read data late");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	chk_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	chk_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper data set");
	chk_supply_timeout: assert property (off_q <= LIM) else $error("supply held too long");
	chk_guard_hold: assert property (guard_q != 0 |-> supply_on_out_n) else $error("button taken in guard");
endmodule : pfrc_top_props

// >>> pfrc_supply_model.sv
// Behavioural main supply: reports power good a few cycles after enable.
// Driven by the active-low enable; dead keeps the rail down.
`timescale 1ns/1ns
module pfrc_supply_model #(
	parameter int unsigned RISE_CYC = 8
) (
	// Clock
	input wire logic aclk,
	// Supply control
	input wire logic supply_on_out_n,
	input wire logic dead,
	// Status
	output logic main_supply_good
);
	int unsigned cnt_q;
	always_ff @(posedge aclk) begin
		cnt_q <= (supply_on_out_n !== 1'b0 || dead) ? 0 : cnt_q + 1;
		main_supply_good <= !dead && supply_on_out_n === 1'b0 && cnt_q >= RISE_CYC;
	end
endmodule : pfrc_supply_model

// >>> pfrc_top_tb.sv
// Testbench for pfrc_top: resume table, every timeout code, button modes.
// Drives AXI4-Lite itself; a supply model answers the enable output.
`timescale 1ns/1ns
module pfrc_top_tb;
	localparam int unsigned MS = 1;
	localparam logic [7:0] PW = pfrc_pkg::PWON_ADDR;
	localparam logic [7:0] MI = pfrc_pkg::MISC_ADDR;
	logic aclk = 0, aresetn = 0, standby_por_pulse = 0, main_por_pulse = 0, dead = 0, s3 = 0, styp_wr = 0;
	logic last_on_at_outage = 0, rtc_alarm_in_outage = 0, button_press_in = 0, pb_q = 0, ovr = 0, s5 = 0;
	logic [2:0] styp = 0;
	logic supply_on_out_n, button_pulse_out, irq, main_good, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int fail_count = 0, samples_checked = 0, pulses = 0, n, t;
	// mode[7:6] ext[5] s3[4] last[3] rtc[2] btn_mode[1] on[0]
	logic [7:0] cases [11] = '{8'h1C, 8'h2C, 8'h31, 8'h68, 8'h45, 8'h71, 8'hB4, 8'h8B, 8'hF0, 8'hC5, 8'hC9};
	wire pfrc_pkg::pfrc_sys_t sys_in = {s3, s5, styp, styp_wr, ovr, main_good};
	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		pulses <= pulses + int'(button_pulse_out === 1'b1 && !pb_q);
		pb_q <= button_pulse_out === 1'b1;
	end
	pfrc_top #(.MS_CYC(MS)) u_pfrc_top (.aclk(aclk), .aresetn(aresetn), .standby_por_pulse(standby_por_pulse),
		.main_por_pulse(main_por_pulse), .last_on_at_outage(last_on_at_outage),
		.rtc_alarm_in_outage(rtc_alarm_in_outage), .sys_in(sys_in), .button_press_in(button_press_in),
		.supply_on_out_n(supply_on_out_n), .button_pulse_out(button_pulse_out), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	pfrc_supply_model u_pfrc_supply_model (.aclk(aclk), .supply_on_out_n(supply_on_out_n), .dead(dead),
		.main_supply_good(main_good));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'(d);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(rd, exp);
	endtask : rchk
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset
	task automatic press(input int hold);
		@(posedge aclk);
		button_press_in <= 1'b1;
		repeat (hold) @(posedge aclk);
		button_press_in <= 1'b0;
		repeat (20) @(posedge aclk);
	endtask : press
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#380000;
		fail_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		do_reset();
		rchk(PW, 32'h87);
		wr(PW, 8'hC7);
		rchk(PW, 32'h07);
		rchk(8'h30, 32'h0);
		chk(32'(rs), 32'(pfrc_pkg::RESP_SLVERR));
		foreach (cases[k]) begin
			do_reset();
			wr(MI, {6'h0, cases[k][1], cases[k][5]});
			wr(PW, {2'b10, cases[k][7:6], 4'h7});
			t = pulses;
			@(posedge aclk);
			standby_por_pulse <= 1'b1;
			s3 <= cases[k][4];
			last_on_at_outage <= cases[k][3];
			rtc_alarm_in_outage <= cases[k][2];
			@(posedge aclk);
			standby_por_pulse <= 1'b0;
			@(posedge aclk);
			s3 <= 1'b0;
			repeat (40) @(posedge aclk);
			chk(32'(supply_on_out_n), 32'(!cases[k][0]));
			chk(pulses - t, 32'(cases[k][0] && !cases[k][1]));
			rchk(PW, {24'h0, 1'b1, cases[k][3], cases[k][7:6], 4'h7});
			rchk(pfrc_pkg::IRQ_STS_ADDR, {30'h0, cases[k][0], 1'b0});
		end
		do_reset();
		dead <= 1'b1;
		wr(pfrc_pkg::IRQ_MASK_ADDR, 8'h01);
		for (int c = 0; c < 8; c++) begin
			wr(PW, 8'(c));
			@(posedge aclk);
			button_press_in <= 1'b1;
			for (n = 0; n < 20 && supply_on_out_n !== 1'b0; n++) @(posedge aclk);
			for (n = 0; n < 20100 && supply_on_out_n !== 1'b1; n++) @(posedge aclk);
			button_press_in <= 1'b0;
			t = pfrc_pkg::TIMEOUT_MS[c] * MS;
			chk(32'(n >= t - 3 && n <= t + 3), 32'h1);
			rchk(MI, 32'h10);
			chk(32'(irq), 32'h1);
			wr(MI, 8'h10);
			wr(pfrc_pkg::IRQ_STS_ADDR, 8'h01);
			rchk(MI, 32'h0);
			chk(32'(irq), 32'h0);
			press(2);
			chk(32'(supply_on_out_n), 32'h1);
			repeat (pfrc_pkg::GUARD_MS * MS) @(posedge aclk);
		end
		dead <= 1'b0;
		do_reset();
		press(2);
		press(2);
		chk(32'(supply_on_out_n), 32'h0);
		@(posedge aclk);
		styp <= 3'h5;
		styp_wr <= 1'b1;
		@(posedge aclk);
		styp_wr <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'(supply_on_out_n), 32'h1);
		rchk(pfrc_pkg::IRQ_STS_ADDR, 32'h4);
		press(2);
		chk(32'(supply_on_out_n), 32'h0);
		ovr <= 1'b1;
		@(posedge aclk);
		ovr <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'(supply_on_out_n), 32'h1);
		press(2);
		chk(32'(supply_on_out_n), 32'h0);
		s5 <= 1'b1;
		@(posedge aclk);
		s5 <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'(supply_on_out_n), 32'h1);
		press(2);
		chk(32'(supply_on_out_n), 32'h0);
		wr(PW, 8'h0F);
		press(2);
		chk(32'(supply_on_out_n), 32'h1);
		@(posedge aclk);
		main_por_pulse <= 1'b1;
		@(posedge aclk);
		main_por_pulse <= 1'b0;
		rchk(PW, 32'h87);
		report_and_stop();
	end
endmodule : pfrc_top_tb
bind pfrc_top pfrc_top_props #(.MS_CYC(MS_CYC)) u_pfrc_top_props (.aclk, .aresetn, .sys_in, .supply_on_out_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
